// file: hw/sac_core.sv
`timescale 1ns/1ns
`include "sac_regs.svh"
// Behaviour
// - Serial mode, select C: data on line ten
// - Chip select and read low drive result
// - Chip select and write low capture control
// - Narrow variants zero the top result bits
// - Serial mode: bit fourteen controls reference buffers
// - Software-mode reset aborts, clears control register
// - Hardware-mode reset configures from select pins
// - Start low in reset needs full pulse
// - Hardware mode samples range at busy fall
// - Software mode takes range from control bits
// - Standby low holds all converters idle
// - Parallel mode, select low: start pins choose pairs
// - Serial mode uses only first start input
// - Word mode uses all sixteen lines
// - Byte mode uses upper eight lines only
// - Byte order select high gives MSB first
module sac_core #(
    parameter int RES_BITS = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic adc_reset_in,
    input wire logic serial_parallel_select_in,
    input wire logic hw_sw_select_in,
    input wire logic word_byte_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic conversion_start_pair_a_in,
    input wire logic conversion_start_pair_b_in,
    input wire logic conversion_start_pair_c_in,
    input wire logic range_in,
    input wire logic standby_n_in,
    input wire logic dout_c_select_in,
    input wire sac_pkg::sac_word_t db_in,
    input wire sac_pkg::sac_results_t conv_result_in,
    output sac_pkg::sac_word_t db_out,
    output sac_pkg::sac_word_t db_oe_out,
    output logic busy_out,
    output logic [2:0] sample_pairs_out,
    output logic [2:0] range_sel_out,
    output logic standby_out,
    output logic ref_buffer_control_out
);
    import sac_pkg::*;

    localparam sac_word_t PAD_MASK = 16'hffff >> (16 - RES_BITS);
    localparam logic [8:0] CONV_LAST = 9'(`SAC_CONV_CYCLES - 1);

    function automatic sac_word_t pad_result(input sac_word_t w);
        pad_result = w & PAD_MASK;
    endfunction

    // Next converted channel after ch, wrapping; channel i belongs to pair i/2
    function automatic logic [2:0] next_channel(input logic [2:0] ch, input logic [2:0] pairs);
        logic [2:0] c;
        logic found;
        c = ch;
        found = 1'b0;
        next_channel = ch;
        for (int k = 0; k < 6; k++) begin
            c = (c == 3'h5) ? 3'h0 : 3'(c + 3'h1);
            if (!found && pairs[c[2:1]]) begin
                next_channel = c;
                found = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    sac_state_t state, next_state;
    logic [8:0] conv_cnt, next_conv_cnt;
    sac_word_t ctrl, next_ctrl;
    logic range_hw, next_range_hw;
    logic [2:0] pairs, next_pairs;
    sac_word_t results [6];
    sac_word_t next_results [6];
    logic [2:0] rd_ch, next_rd_ch;
    logic byte_sec, next_byte_sec;
    logic [2:0] start_armed, next_start_armed;
    logic [2:0] start_prev;
    logic read_prev, sclk_prev;
    logic [31:0] shift, next_shift;
    sac_word_t next_db_out;
    logic [2:0] starts, start_rise, launch_pairs;
    logic serial, read_act, write_act, dout_c_act, msb_now;
    sac_word_t cur_word;

    assign starts = {conversion_start_pair_c_in, conversion_start_pair_b_in,
                     conversion_start_pair_a_in};
    assign serial = serial_parallel_select_in;
    assign read_act = !serial && !cs_n_in && !rd_n_in;
    assign write_act = !serial && !cs_n_in && !wr_n_in;
    assign dout_c_act = serial && dout_c_select_in && !cs_n_in;
    // Only a rise that follows a seen fall counts as a start
    assign start_rise = starts & ~start_prev & start_armed;

    always_comb begin
        next_state = state;
        next_conv_cnt = conv_cnt;
        next_ctrl = ctrl;
        next_range_hw = range_hw;
        next_pairs = pairs;
        next_results = results;
        next_rd_ch = rd_ch;
        next_byte_sec = byte_sec;
        next_start_armed = start_armed | (~starts & start_prev);
        next_shift = shift;
        launch_pairs = 3'h0;
        if (serial) begin
            launch_pairs = start_rise[0] ? (hw_sw_select_in ?
                ctrl[`SAC_CTRL_PAIR_LSB +: 3] : 3'h7) : 3'h0;
        end else if (hw_sw_select_in) begin
            launch_pairs = start_rise[0] ? ctrl[`SAC_CTRL_PAIR_LSB +: 3] : 3'h0;
        end else begin
            launch_pairs = start_rise;
        end
        case (state)
            SAC_IDLE: begin
                if (launch_pairs != 3'h0 && standby_n_in) begin
                    next_state = SAC_CONVERT;
                    next_conv_cnt = CONV_LAST;
                    next_pairs = launch_pairs;
                end
            end
            SAC_CONVERT: begin
                if (conv_cnt == 9'h0) begin
                    next_state = SAC_IDLE;
                    for (int i = 0; i < 6; i++) begin
                        if (pairs[i / 2]) begin
                            next_results[i] = pad_result(conv_result_in[i]);
                        end
                    end
                    if (!hw_sw_select_in) begin
                        next_range_hw = range_in;
                    end
                    next_rd_ch = next_channel(3'h5, pairs);
                    next_byte_sec = 1'b0;
                    next_shift = {pad_result(conv_result_in[4]), pad_result(conv_result_in[5])};
                end else begin
                    next_conv_cnt = 9'(conv_cnt - 9'h1);
                end
            end
            default: next_state = SAC_IDLE;
        endcase
        if (write_act) begin
            next_ctrl = db_in;
        end
        if (read_prev && !read_act) begin
            if (word_byte_in && !byte_sec) begin
                next_byte_sec = 1'b1;
            end else begin
                next_byte_sec = 1'b0;
                next_rd_ch = next_channel(rd_ch, pairs);
            end
        end
        if (serial && db_in[`SAC_SCLK_BIT] && !sclk_prev) begin
            next_shift = {shift[30:0], 1'b0};
        end
        if (adc_reset_in) begin
            // Abort anything in flight; a start held low must pulse again
            next_state = SAC_IDLE;
            next_conv_cnt = 9'h0;
            next_start_armed = starts;
            next_rd_ch = 3'h0;
            next_byte_sec = 1'b0;
            if (hw_sw_select_in) begin
                next_ctrl = `SAC_CTRL_RESET;
            end else begin
                next_range_hw = range_in;
            end
        end
    end

    // Data leaves through a flop, so it trails the strobe by one cycle
    always_comb begin
        cur_word = results[rd_ch];
        msb_now = db_in[`SAC_BYTE_ORDER_BIT] ^ byte_sec;
        next_db_out = 16'h0;
        if (serial) begin
            next_db_out[`SAC_DOUT_C_BIT] = shift[31];
        end else if (word_byte_in) begin
            next_db_out[15:8] = msb_now ? cur_word[15:8] : cur_word[7:0];
        end else begin
            next_db_out = cur_word;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= SAC_IDLE;
            conv_cnt <= 9'h0;
            ctrl <= `SAC_CTRL_RESET;
            range_hw <= 1'b0;
            pairs <= 3'h0;
            for (int i = 0; i < 6; i++) begin
                results[i] <= 16'h0;
            end
            rd_ch <= 3'h0;
            byte_sec <= 1'b0;
            start_armed <= 3'h0;
            start_prev <= 3'h0;
            read_prev <= 1'b0;
            sclk_prev <= 1'b0;
            shift <= 32'h0;
            db_out <= 16'h0;
        end else if (clk_en_in) begin
            state <= next_state;
            conv_cnt <= next_conv_cnt;
            ctrl <= next_ctrl;
            range_hw <= next_range_hw;
            pairs <= next_pairs;
            results <= next_results;
            rd_ch <= next_rd_ch;
            byte_sec <= next_byte_sec;
            start_armed <= next_start_armed;
            start_prev <= starts;
            read_prev <= read_act;
            sclk_prev <= db_in[`SAC_SCLK_BIT];
            shift <= next_shift;
            db_out <= next_db_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host owns the lines during writes, so only reads or serial C drive them
    assign db_oe_out = read_act ? (word_byte_in ? `SAC_OE_BYTE : `SAC_OE_WORD)
                     : (dout_c_act ? `SAC_OE_DOUT_C : 16'h0);
    assign busy_out = (state == SAC_CONVERT);
    assign sample_pairs_out = busy_out ? pairs : 3'h0;
    assign range_sel_out = hw_sw_select_in ? ctrl[`SAC_CTRL_RNG_LSB +: 3]
                         : {3{range_hw}};
    assign standby_out = !standby_n_in;
    assign ref_buffer_control_out = serial && db_in[`SAC_REFBUF_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_word_read: assert property (read_act && !word_byte_in |-> db_oe_out == 16'hffff)
        else $error("word read does not drive all lines");
    a_byte_read: assert property (read_act && word_byte_in |-> db_oe_out == 16'hff00)
        else $error("byte read drives wrong lanes");
    a_lines_float: assert property (!read_act && !dout_c_act |-> db_oe_out == 16'h0)
        else $error("data lines driven while idle");
    a_serial_c_drive: assert property (dout_c_act |-> db_oe_out == 16'h0400)
        else $error("serial line C not driven alone");
    a_write_capture: assert property (clk_en_in && write_act && !adc_reset_in
        |=> ctrl == $past(db_in))
        else $error("control word not captured");
    a_reset_clear: assert property (clk_en_in && adc_reset_in && hw_sw_select_in
        |=> ctrl == 16'h0 && !busy_out)
        else $error("software reset did not clear");
    a_pad_zero: assert property ((results[rd_ch] & ~PAD_MASK) == 16'h0)
        else $error("unpadded result bits");
    a_range_hw: assert property (clk_en_in && busy_out && conv_cnt == 9'h0
        && !hw_sw_select_in && !adc_reset_in
        |=> hw_sw_select_in || range_sel_out == {3{$past(range_in)}})
        else $error("range not taken at busy fall");
    a_range_sw: assert property (hw_sw_select_in
        |-> range_sel_out == ctrl[`SAC_CTRL_RNG_LSB +: 3])
        else $error("software range mismatch");
    a_standby_hold: assert property (clk_en_in && !standby_n_in && !busy_out |=> !busy_out)
        else $error("conversion started in standby");
    a_hw_pairs: assert property (clk_en_in && !adc_reset_in && !busy_out && !serial
        && !hw_sw_select_in && standby_n_in && start_rise != 3'h0
        |=> sample_pairs_out == $past(start_rise))
        else $error("wrong pairs sampled");
    a_serial_start: assert property (clk_en_in && serial && !busy_out && !start_rise[0]
        |=> !busy_out)
        else $error("serial conversion without first start");

    c_conversion: cover property (busy_out ##1 !busy_out);
    c_byte_read: cover property (read_act && word_byte_in ##1 !read_act);
    c_serial_out: cover property (dout_c_act && db_out[10]);
    c_sw_write: cover property (write_act && hw_sw_select_in);
endmodule

// file: hw/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Control word fields: pair select (A,B,C) and range bits (A,B,C)
`define SAC_CTRL_PAIR_LSB 5
`define SAC_CTRL_RNG_LSB 2
`define SAC_CTRL_RESET 16'h0000

// Shared data line positions
`define SAC_SCLK_BIT 6
`define SAC_BYTE_ORDER_BIT 7
`define SAC_DOUT_C_BIT 10
`define SAC_REFBUF_BIT 14
`define SAC_OE_WORD 16'hffff
`define SAC_OE_BYTE 16'hff00
`define SAC_OE_DOUT_C 16'h0400

// Conversion timing from the internal oscillator
`define SAC_CLK_PERIOD_NS 10
`define SAC_CONV_TIME_NS 3000
`define SAC_CONV_CYCLES ((`SAC_CONV_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// file: hw/sac_pkg.sv
package sac_pkg;
    typedef logic [15:0] sac_word_t;
    typedef logic [5:0][15:0] sac_results_t;
    typedef enum logic {SAC_IDLE, SAC_CONVERT} sac_state_t;
endpackage

// file: testbench/sac_host.sv
`timescale 1ns/1ns
module sac_host (
    input wire logic clk_in,
    input wire sac_pkg::sac_word_t dev_db_in,
    input wire sac_pkg::sac_word_t dev_oe_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output sac_pkg::sac_word_t pin_db_out
);
    import sac_pkg::*;
    sac_word_t host_val;
    sac_word_t drv;
    // Host drives byte order, serial clock and reference buffer lines between transfers
    // Undriven lines show the inverse of the last host value, so stale data never matches
    assign pin_db_out = (dev_oe_in & dev_db_in) | (~dev_oe_in & ((drv & host_val) | (~drv & ~host_val)));
    initial begin
        {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
        host_val = 16'h0000;
        drv = 16'h40c0;
    end
    task automatic lines(input sac_word_t v);
        @(posedge clk_in);
        host_val <= v;
    endtask
    task automatic rd(output sac_word_t v, output sac_word_t oe);
        @(posedge clk_in);
        cs_n_out <= 1'h0;
        rd_n_out <= 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        v = pin_db_out;
        oe = dev_oe_in;
        @(posedge clk_in);
        {cs_n_out, rd_n_out} <= 2'h3;
        @(posedge clk_in);
    endtask
    task automatic wr(input sac_word_t v, output sac_word_t oe);
        @(posedge clk_in);
        host_val <= v;
        drv <= 16'hffff;
        {cs_n_out, wr_n_out} <= 2'h0;
        @(posedge clk_in);
        #1;
        oe = dev_oe_in;
        @(posedge clk_in);
        {cs_n_out, wr_n_out} <= 2'h3;
        drv <= 16'h40c0;
    endtask
endmodule

// file: testbench/tb_sac_core.sv
`timescale 1ns/1ns
`include "sac_regs.svh"
module tb_sac_core;
    import sac_pkg::*;
    logic clk_in, sys_rst_in, adc_reset, ser_sel, hw_sw, word_byte, range_pin, dout_c_sel;
    logic standby_n, cs_n, rd_n, wr_n, busy, standby, ref_buf;
    logic [2:0] st, pairs, range_sel;
    sac_word_t pin_db, db_out, db_oe, got, oe;
    sac_results_t results;
    int miscompares, cmp_count;
    sac_core sac_core_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'h1), .adc_reset_in(adc_reset),
        .serial_parallel_select_in(ser_sel), .hw_sw_select_in(hw_sw), .word_byte_in(word_byte),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .conversion_start_pair_a_in(st[0]),
        .conversion_start_pair_b_in(st[1]), .conversion_start_pair_c_in(st[2]),
        .range_in(range_pin), .standby_n_in(standby_n), .dout_c_select_in(dout_c_sel),
        .db_in(pin_db), .conv_result_in(results), .db_out(db_out), .db_oe_out(db_oe),
        .busy_out(busy), .sample_pairs_out(pairs), .range_sel_out(range_sel),
        .standby_out(standby), .ref_buffer_control_out(ref_buf));
    sac_host sac_host_inst (.clk_in(clk_in), .dev_db_in(db_out), .dev_oe_in(db_oe),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .pin_db_out(pin_db));
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input sac_word_t g, input sac_word_t e, input string msg);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, g, e);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        for (int k = 0; busy !== v; k++) begin
            if (k == 400) begin
                miscompares++;
                test_done();
            end
            @(posedge clk_in);
            #1;
        end
    endtask
    // Only the pins in the mask fall; the others stay high so they do not re-arm
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_in);
        st <= ~m;
        @(posedge clk_in);
        st <= 3'h7;
    endtask
    task automatic convert(input logic [2:0] m, input logic [2:0] ep);
        time t0;
        pulse(m);
        wait_busy(1'h1);
        t0 = $time;
        chk(16'(pairs), 16'(ep), "pairs");
        wait_busy(1'h0);
        chk(16'(($time - t0) / 10), 16'(`SAC_CONV_CYCLES), "busy length");
    endtask
    task automatic t_start_low();
        @(posedge clk_in);
        st <= 3'h7;
        repeat (4) @(posedge clk_in);
        #1;
        chk(16'(busy), 16'h0000, "rise only");
        $display("test start_low done");
    endtask
    task automatic t_hw_word();
        for (int r = 1; r >= 0; r--) begin
            @(posedge clk_in);
            range_pin <= r[0];
            convert(3'h3, 3'h3);
            chk(16'(range_sel), 16'({3{r[0]}}), "range");
            for (int i = 0; i < 4; i++) begin
                sac_host_inst.rd(got, oe);
                chk(got, results[i], "word");
                chk(oe, `SAC_OE_WORD, "word oe");
            end
            chk(db_oe, 16'h0000, "released");
        end
        range_pin <= 1'h1;
        adc_reset <= 1'h1;
        repeat (10) @(posedge clk_in);
        adc_reset <= 1'h0;
        #1;
        chk(16'(range_sel), 16'h0007, "hw reset range");
        $display("test hw_word done");
    endtask
    task automatic t_byte();
        for (int h = 1; h >= 0; h--) begin
            sac_host_inst.lines(16'({h[0], 7'h00}));
            word_byte <= 1'h1;
            convert(3'h1, 3'h1);
            sac_host_inst.rd(got, oe);
            chk(16'(got[15:8]), 16'(h ? results[0][15:8] : results[0][7:0]), "byte 1");
            chk(oe, `SAC_OE_BYTE, "byte oe");
            sac_host_inst.rd(got, oe);
            chk(16'(got[15:8]), 16'(h ? results[0][7:0] : results[0][15:8]), "byte 2");
        end
        word_byte <= 1'h0;
        $display("test byte done");
    endtask
    task automatic t_sw();
        @(posedge clk_in);
        {hw_sw, range_pin} <= 2'h2;
        sac_host_inst.wr(16'h0074, oe);
        #1;
        chk(oe, 16'h0000, "write oe");
        chk(16'(range_sel), 16'h0005, "sw range");
        convert(3'h1, 3'h3);
        pulse(3'h1);
        wait_busy(1'h1);
        @(posedge clk_in);
        adc_reset <= 1'h1;
        repeat (10) @(posedge clk_in);
        adc_reset <= 1'h0;
        #1;
        chk(16'(busy), 16'h0000, "abort");
        chk(16'(range_sel), 16'h0000, "ctrl cleared");
        @(posedge clk_in);
        hw_sw <= 1'h0;
        $display("test sw done");
    endtask
    task automatic t_standby();
        @(posedge clk_in);
        standby_n <= 1'h0;
        pulse(3'h7);
        repeat (4) @(posedge clk_in);
        #1;
        chk(16'(standby), 16'h0001, "standby");
        chk(16'(busy), 16'h0000, "start in standby");
        @(posedge clk_in);
        standby_n <= 1'h1;
        $display("test standby done");
    endtask
    task automatic t_serial();
        @(posedge clk_in);
        {ser_sel, dout_c_sel} <= 2'h3;
        for (int b = 0; b < 2; b++) begin
            sac_host_inst.lines(16'({b[0], 14'h0000}));
            #1;
            chk(16'(ref_buf), 16'(b), "ref buffer");
        end
        pulse(3'h6);
        repeat (4) @(posedge clk_in);
        #1;
        chk(16'(busy), 16'h0000, "serial B C start");
        convert(3'h1, 3'h7);
        sac_host_inst.rd(got, oe);
        chk(oe, `SAC_OE_DOUT_C, "third output");
        chk(16'(got[10]), 16'(results[4][15]), "serial first bit");
        // Serial clock is bit six; one rising edge moves the next bit out
        sac_host_inst.lines(16'h4040);
        sac_host_inst.rd(got, oe);
        chk(16'(got[10]), 16'(results[4][14]), "serial second bit");
        $display("test serial done");
    endtask
    initial begin
        {sys_rst_in, adc_reset, ser_sel, hw_sw, word_byte, range_pin, dout_c_sel} = 7'h40;
        standby_n = 1'h1;
        st = 3'h0;
        results = {16'hc6f6, 16'hb5e5, 16'ha4d4, 16'h93c3, 16'h82b2, 16'h71a1};
        {miscompares, cmp_count} = 64'h0;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        adc_reset <= 1'h1;
        repeat (10) @(posedge clk_in);
        adc_reset <= 1'h0;
        t_start_low();
        t_hw_word();
        t_byte();
        t_sw();
        t_standby();
        t_serial();
        test_done();
    end
endmodule
